// file: hdl/sla_map.svh
`ifndef SLA_MAP_SVH
`define SLA_MAP_SVH
// register offsets (byte addresses on the plain register port)
`define SLA_OFF_CTRL        8'h00
`define SLA_OFF_STATUS      8'h04
`define SLA_OFF_LAT_FREQ    8'h08
`define SLA_OFF_LAT_PHASE   8'h0C
`define SLA_OFF_LAT_AMP     8'h10
`define SLA_OFF_OUT_FREQ    8'h14
`define SLA_OFF_OUT_PHASE   8'h18
`define SLA_OFF_OUT_AMP     8'h1C
// control register field positions
`define SLA_CTRL_MODE_LSB   0
`define SLA_CTRL_MODE_MSB   1
`define SLA_CTRL_MATCH_BIT  2
`define SLA_CTRL_KEY_BIT    3
`define SLA_CTRL_RESET      4'h0
// mode field codes
`define SLA_MODE_CODE_SINGLE   2'h0
`define SLA_MODE_CODE_PARALLEL 2'h1
`define SLA_MODE_CODE_SWEEP    2'h2
// datapath widths
`define SLA_FREQ_W          32
`define SLA_PHASE_W         16
`define SLA_AMP_W           12
`define SLA_LAT_W           9
`define SLA_DEPTH           512
// update selector codes
`define SLA_SEL_FREQ        2'h0
`define SLA_SEL_PHASE       2'h1
`define SLA_SEL_AMP         2'h2
// pipeline delays in core sample clock cycles
`define SLA_LAT_FREQ_BASE   9'h13E
`define SLA_LAT_PHASE_BASE  9'h126
`define SLA_LAT_AMP_BASE    9'h066
`define SLA_LAT_AMP_MATCH   9'h156
`define SLA_LAT_KEY_STEP    9'h018
`define SLA_LAT_SWEEP_STEP  9'h018
`endif

// file: hdl/sla_pkg.sv
`include "sla_map.svh"
package sla_pkg;
   // operating modes of the synthesizer pipeline
   typedef enum {
      SLA_MODE_SINGLE,
      SLA_MODE_PARALLEL,
      SLA_MODE_SWEEP
   } sla_mode_type;

   // one queued parameter update
   typedef struct packed {
      logic [1:0]             sel;
      logic [`SLA_FREQ_W-1:0] data;
   } sla_upd_type;
endpackage

// file: hdl/sla_buf2.sv
`timescale 1ns/1ps
`default_nettype none
`include "sla_map.svh"
// two-entry buffer; a stall by the drain side fills it and drops o_in_ready
module sla_buf2
   import sla_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   input  wire logic        i_in_valid,
   input  wire sla_upd_type i_in_data,
   output logic             o_in_ready,
   output logic             o_out_valid,
   output sla_upd_type      o_out_data,
   input  wire logic        i_out_ready
);
   typedef struct packed {
      sla_upd_type [1:0] slot;  // slot 0 is the head
      logic [1:0]        cnt;   // entries held
      logic              full;  // registered full flag
   } sla_buf_type;

   sla_buf_type st_q;
   sla_buf_type st_d;
   logic        push;
   logic        pop;

   // push/pop bookkeeping
   always_comb
   begin
      st_d = st_q;
      push = i_in_valid && !st_q.full;
      pop  = (st_q.cnt != 2'h0) && i_out_ready;
      if (pop)
      begin
         st_d.slot[0] = st_q.slot[1];
      end
      if (push)
      begin
         // new word lands behind whatever survives the pop
         if (st_q.cnt - {1'b0, pop} == 2'h0)
         begin
            st_d.slot[0] = i_in_data;
         end
         else
         begin
            st_d.slot[1] = i_in_data;
         end
      end
      st_d.cnt  = st_q.cnt + {1'b0, push} - {1'b0, pop};
      st_d.full = (st_d.cnt == 2'h2);
   end

   // state register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_in_ready  = !st_q.full;
   assign o_out_valid = (st_q.cnt != 2'h0);
   assign o_out_data  = st_q.slot[0];
endmodule
`default_nettype wire

// file: hdl/sla_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "sla_map.svh"
// fixed-rate delay line: a value loaded in cycle t shows at o_data in cycle t+lat
module sla_delay
   import sla_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_load,
   input  wire logic [W-1:0]          i_data,
   input  wire logic [`SLA_LAT_W-1:0] i_lat,
   output logic [W-1:0]               o_data
);
   typedef struct packed {
      logic [`SLA_LAT_W-1:0] ptr;   // write pointer
      logic [`SLA_LAT_W-1:0] age;   // cycles written, saturating
      logic [W-1:0]          held;  // newest parameter value
      logic [W-1:0]          out;   // registered output
   } sla_dly_type;

   sla_dly_type           st_q;
   sla_dly_type           st_d;
   logic [W-1:0]          mem [0:`SLA_DEPTH-1];  // sample history
   logic [W-1:0]          wdata;
   logic [`SLA_LAT_W-1:0] ridx;

   // every core sample clock writes one history word; delay counts those cycles
   always_comb
   begin
      st_d  = st_q;
      wdata = i_load ? i_data : st_q.held;
      ridx  = st_q.ptr - (i_lat - 9'h001);
      st_d.held = wdata;
      st_d.ptr  = st_q.ptr + 9'h001;
      if (st_q.age != 9'h1FF)
      begin
         st_d.age = st_q.age + 9'h001;
      end
      // until enough history exists, keep the reset value
      if (st_q.age >= i_lat - 9'h001)
      begin
         st_d.out = (ridx == st_q.ptr) ? wdata : mem[ridx];
      end
   end

   // history memory
   always_ff @(posedge i_clk_sys)
   begin
      mem[st_q.ptr] <= wdata;
   end

   // state register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_data = st_q.out;
endmodule
`default_nettype wire

// file: hdl/sla_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sla_map.svh"
module sla_top
   import sla_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_sys_rst,
   // register port
   input  wire logic [7:0]              i_addr,
   input  wire logic [31:0]             i_wr_data,
   input  wire logic                    i_wr_en,
   input  wire logic                    i_rd_en,
   output logic [31:0]                  o_rd_data,
   // parameter update stream
   input  wire logic                    i_upd_valid,
   input  wire logic [1:0]              i_upd_sel,
   input  wire logic [`SLA_FREQ_W-1:0]  i_upd_data,
   output logic                         o_upd_ready,
   input  wire logic                    i_upd_hold,
   // synthesizer parameter outputs
   output logic [`SLA_FREQ_W-1:0]       o_freq,
   output logic [`SLA_PHASE_W-1:0]      o_phase,
   output logic [`SLA_AMP_W-1:0]        o_amp
);
   typedef struct packed {
      logic [1:0]            mode_code;         // operating mode field
      logic                  match_lat;         // matched latency enable
      logic                  amplitude_keying;  // amplitude keying enable
      logic [31:0]           rd_data;           // read data, one cycle after strobe
      logic [`SLA_LAT_W-1:0] lat_freq;          // current frequency delay
      logic [`SLA_LAT_W-1:0] lat_phase;         // current phase delay
      logic [`SLA_LAT_W-1:0] lat_amp;           // current amplitude delay
   } sla_top_type;

   sla_top_type                st_q;
   sla_top_type                st_d;
   sla_mode_type               mode;          // decoded mode
   sla_upd_type                in_word;       // word entering the buffer
   sla_upd_type                head;          // word leaving the buffer
   logic                       head_valid;    // buffer holds a word
   logic                       take;          // pipeline accepts the head
   logic                       buf_ready;     // buffer has room
   logic                       load_freq;     // load strobes per path
   logic                       load_phase;
   logic                       load_amp;
   logic [`SLA_FREQ_W-1:0]     dly_freq;      // delay line outputs
   logic [`SLA_PHASE_W-1:0]    dly_phase;
   logic [`SLA_AMP_W-1:0]      dly_amp;
   logic [`SLA_LAT_W-1:0]      add_sweep;     // sweep mode extra delay
   logic [`SLA_LAT_W-1:0]      add_key;       // amplitude keying extra delay
   logic                       ready_q;       // registered copy of buffer room

   // update words enter a two-entry buffer; i_upd_hold stalls the drain
   assign in_word.sel  = i_upd_sel;
   assign in_word.data = i_upd_data;

   sla_buf2 u_buf (
      .i_clk_sys   (i_clk_sys),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (i_upd_valid),
      .i_in_data   (in_word),
      .o_in_ready  (buf_ready),
      .o_out_valid (head_valid),
      .o_out_data  (head),
      .i_out_ready (!i_upd_hold)
   );

   // steer the accepted word to one parameter path; an unused selector code loads none
   always_comb
   begin
      take       = head_valid && !i_upd_hold;
      load_freq  = take && (head.sel == `SLA_SEL_FREQ);
      load_phase = take && (head.sel == `SLA_SEL_PHASE);
      load_amp   = take && (head.sel == `SLA_SEL_AMP);
   end

   // decode the mode field; unused code falls back to single tone
   always_comb
   begin
      case (st_q.mode_code)
         `SLA_MODE_CODE_PARALLEL: mode = SLA_MODE_PARALLEL;
         `SLA_MODE_CODE_SWEEP:    mode = SLA_MODE_SWEEP;
         default:                 mode = SLA_MODE_SINGLE;
      endcase
   end

   // register port and latency selection
   always_comb
   begin
      st_d = st_q;
      // mode dependent extra stages
      case (mode)
         SLA_MODE_SWEEP:
         begin
            add_sweep = `SLA_LAT_SWEEP_STEP;
         end
         SLA_MODE_PARALLEL:
         begin
            add_sweep = 9'h000;
         end
         default:
         begin
            add_sweep = 9'h000;
         end
      endcase
      add_key = st_q.amplitude_keying ? `SLA_LAT_KEY_STEP : 9'h000;
      if (st_q.match_lat)
      begin
         // frequency and phase share one delay; amplitude is padded up
         st_d.lat_freq  = `SLA_LAT_FREQ_BASE + add_key + add_sweep;
         st_d.lat_phase = `SLA_LAT_FREQ_BASE + add_key + add_sweep;
         st_d.lat_amp   = `SLA_LAT_AMP_MATCH + add_sweep;
      end
      else
      begin
         st_d.lat_freq  = `SLA_LAT_FREQ_BASE + add_key + add_sweep;
         st_d.lat_phase = `SLA_LAT_PHASE_BASE + add_key + add_sweep;
         st_d.lat_amp   = `SLA_LAT_AMP_BASE + add_sweep;
      end
      // writes: only the control register is writable
      if (i_wr_en && (i_addr == `SLA_OFF_CTRL))
      begin
         st_d.mode_code        = i_wr_data[`SLA_CTRL_MODE_MSB:`SLA_CTRL_MODE_LSB];
         st_d.match_lat        = i_wr_data[`SLA_CTRL_MATCH_BIT];
         st_d.amplitude_keying = i_wr_data[`SLA_CTRL_KEY_BIT];
      end
      // reads: data stand only in the cycle after the strobe
      st_d.rd_data = 32'h0000_0000;
      if (i_rd_en)
      begin
         case (i_addr)
            `SLA_OFF_CTRL:
            begin
               st_d.rd_data = {28'h000_0000, st_q.amplitude_keying, st_q.match_lat, st_q.mode_code};
            end
            `SLA_OFF_STATUS:
            begin
               st_d.rd_data = {29'h0000_0000, i_upd_hold, head_valid, !ready_q};
            end
            `SLA_OFF_LAT_FREQ:
            begin
               st_d.rd_data = {23'h00_0000, st_q.lat_freq};
            end
            `SLA_OFF_LAT_PHASE:
            begin
               st_d.rd_data = {23'h00_0000, st_q.lat_phase};
            end
            `SLA_OFF_LAT_AMP:
            begin
               st_d.rd_data = {23'h00_0000, st_q.lat_amp};
            end
            `SLA_OFF_OUT_FREQ:
            begin
               st_d.rd_data = dly_freq;
            end
            `SLA_OFF_OUT_PHASE:
            begin
               st_d.rd_data = {16'h0000, dly_phase};
            end
            `SLA_OFF_OUT_AMP:
            begin
               st_d.rd_data = {20'h0_0000, dly_amp};
            end
            default:
            begin
               st_d.rd_data = 32'h0000_0000;  // unmapped reads return zero
            end
         endcase
      end
   end

   // state register; latencies come up at the single tone unmatched values
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st_q.mode_code        <= 2'h0;
         st_q.match_lat        <= 1'b0;
         st_q.amplitude_keying <= 1'b0;
         st_q.rd_data          <= 32'h0000_0000;
         st_q.lat_freq         <= `SLA_LAT_FREQ_BASE;
         st_q.lat_phase        <= `SLA_LAT_PHASE_BASE;
         st_q.lat_amp          <= `SLA_LAT_AMP_BASE;
         ready_q               <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         ready_q <= buf_ready;
      end
   end

   // three delay lines, one per parameter path
   sla_delay #(.W(`SLA_FREQ_W)) u_dly_freq (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_load    (load_freq),
      .i_data    (head.data),
      .i_lat     (st_q.lat_freq),
      .o_data    (dly_freq)
   );

   sla_delay #(.W(`SLA_PHASE_W)) u_dly_phase (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_load    (load_phase),
      .i_data    (head.data[`SLA_PHASE_W-1:0]),
      .i_lat     (st_q.lat_phase),
      .o_data    (dly_phase)
   );

   sla_delay #(.W(`SLA_AMP_W)) u_dly_amp (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_load    (load_amp),
      .i_data    (head.data[`SLA_AMP_W-1:0]),
      .i_lat     (st_q.lat_amp),
      .o_data    (dly_amp)
   );

   // outputs straight from flops
   assign o_rd_data   = st_q.rd_data;
   assign o_upd_ready = buf_ready;
   assign o_freq      = dly_freq;
   assign o_phase     = dly_phase;
   assign o_amp       = dly_amp;
endmodule
`default_nettype wire

// file: dv/sla_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sla_map.svh"
// port-level checker for the latency block
module sla_top_sva
   import sla_pkg::*;
(
   input wire logic                   i_clk_sys,
   input wire logic                   i_sys_rst,
   input wire logic [7:0]             i_addr,
   input wire logic [31:0]            i_wr_data,
   input wire logic                   i_wr_en,
   input wire logic                   i_rd_en,
   input wire logic [31:0]            o_rd_data,
   input wire logic                   i_upd_valid,
   input wire logic                   o_upd_ready,
   input wire logic                   i_upd_hold,
   input wire logic [`SLA_FREQ_W-1:0] o_freq,
   input wire logic [`SLA_PHASE_W-1:0] o_phase,
   input wire logic [`SLA_AMP_W-1:0]  o_amp
);
   localparam int QUIET = 32'h190; // longer than any path plus drain
   int idle_cnt;                    // cycles with no take, hold or register write
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // counts quiet cycles so that settled outputs can be checked
   always_ff @(posedge i_clk_sys)
   begin
      idle_cnt <= (i_sys_rst || i_wr_en || i_upd_hold || (i_upd_valid && o_upd_ready)) ? 0 :
                  ((idle_cnt >= QUIET) ? idle_cnt : idle_cnt + 1);
   end
   sequence held_take; i_upd_valid && o_upd_ready && i_upd_hold; endsequence
   sequence ctrl_wr; i_wr_en && i_addr == 8'h00; endsequence
   sequence ctrl_rd; i_rd_en && i_addr == 8'h00; endsequence
   rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 32'h0) else $error("read data not cleared");
   full_stall_a: assert property (held_take ##1 held_take |=> !o_upd_ready) else $error("buffer took a third word");
   hold_keep_a: assert property (i_upd_hold && !o_upd_ready |=> !o_upd_ready) else $error("held buffer drained");
   status_a: assert property (i_rd_en && i_addr == 8'h04 |=> o_rd_data[31:3] == 29'h0 &&
      o_rd_data[2] == $past(i_upd_hold)) else $error("status word wrong");
   ctrl_back_a: assert property (ctrl_wr ##1 ctrl_rd |=> o_rd_data[3:0] == $past(i_wr_data[3:0], 2))
      else $error("control readback wrong");
   lat_freq_a: assert property (i_rd_en && i_addr == 8'h08 |=> o_rd_data inside {32'h13E, 32'h156, 32'h16E})
      else $error("frequency delay out of set");
   lat_phase_a: assert property (i_rd_en && i_addr == 8'h0C |=>
      o_rd_data inside {32'h126, 32'h13E, 32'h156, 32'h16E}) else $error("phase delay out of set");
   lat_amp_a: assert property (i_rd_en && i_addr == 8'h10 |=>
      o_rd_data inside {32'h66, 32'h7E, 32'h156, 32'h16E}) else $error("amplitude delay out of set");
   out_read_a: assert property (i_rd_en && i_addr == 8'h14 |=> o_rd_data == $past(o_freq))
      else $error("frequency readback wrong");
   settle_a: assert property (idle_cnt >= QUIET |-> $stable(o_freq) && $stable(o_phase) && $stable(o_amp))
      else $error("output moved with nothing in flight");
endmodule
bind sla_top sla_top_sva i_sla_top_sva (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
   .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_upd_valid(i_upd_valid),
   .o_upd_ready(o_upd_ready), .i_upd_hold(i_upd_hold), .o_freq(o_freq), .o_phase(o_phase), .o_amp(o_amp));
`default_nettype wire

// file: dv/sla_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: offers queued update words, holds each until taken
module sla_host_model
   import sla_pkg::*;
(
   input  wire logic  i_clk_sys,
   input  wire logic  i_sys_rst,
   input  wire logic  i_slow,
   input  wire logic  i_ready,
   output logic       o_valid,
   output logic [1:0] o_sel,
   output logic [31:0] o_data
);
   sla_upd_type q[$]; // words waiting to be offered
   logic        gap;  // toggles to space words out in slow mode
   initial
   begin
      o_valid = 1'b0;
      o_sel = 2'h0;
      o_data = 32'h0;
      gap = 1'b0;
   end
   // queue one word; called away from the rising edge
   task automatic push(input logic [1:0] sel, input logic [31:0] data);
      q.push_back({sel, data});
   endtask
   // offer the head word; released lines show inverted stale data
   always @(posedge i_clk_sys)
   begin
      gap <= i_slow ? !gap : 1'b0;
      if (o_valid && i_ready)
         void'(q.pop_front());
      if (!i_sys_rst && q.size() > 0 && ((o_valid && !i_ready) || !(i_slow && gap)))
      begin
         o_valid <= 1'b1;
         o_sel <= q[0].sel;
         o_data <= q[0].data;
      end
      else
      begin
         o_valid <= 1'b0;
         o_sel <= ~o_sel;
         o_data <= ~o_data;
      end
   end
endmodule
`default_nettype wire

// file: dv/sla_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sla_map.svh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %s", $time, m); end end
module sla_top_tb;
   import sla_pkg::*;
   logic        i_clk_sys, i_sys_rst, i_wr_en, i_rd_en, i_upd_hold, slow, upd_valid, upd_ready;
   logic [7:0]  i_addr;
   logic [1:0]  upd_sel;
   logic [31:0] i_wr_data, o_rd_data, upd_data, o_freq, val;
   logic [15:0] o_phase;
   logic [11:0] o_amp;
   logic [31:0] cur [3], prv [3], last [3]; // outputs now, at last edge, and as the model expects
   int          n_fail, comparisons, cyc, t_take, seed;
   int          t_chg [3];                   // edge after the one at which each output last moved
   sla_top i_sla_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_upd_valid(upd_valid), .i_upd_sel(upd_sel),
      .i_upd_data(upd_data), .o_upd_ready(upd_ready), .i_upd_hold(i_upd_hold), .o_freq(o_freq),
      .o_phase(o_phase), .o_amp(o_amp));
   sla_host_model i_sla_host_model (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_slow(slow),
      .i_ready(upd_ready), .o_valid(upd_valid), .o_sel(upd_sel), .o_data(upd_data));
   assign cur[0] = o_freq;
   assign cur[1] = {16'h0, o_phase};
   assign cur[2] = {20'h0, o_amp};
   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   // edge monitor: handshake moments and output changes
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (upd_valid && upd_ready) t_take = cyc;
      for (int p = 0; p < 3; p++)
      begin
         if (cur[p] !== prv[p]) t_chg[p] = cyc;
         prv[p] = cur[p];
      end
   end
   // expected delay for control code c on path p
   function automatic int lat(int c, int p);
      int l;
      l = (p == 2) ? (c[2] ? 32'h156 : 32'h66) : ((p == 1 && !c[2]) ? 32'h126 : 32'h13E);
      if (p != 2 && c[3]) l += 32'h18;
      if (c[1:0] == 2'h2) l += 32'h18;
      return l;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      @(negedge i_clk_sys);
      `CHK(o_rd_data, e, m)
      @(posedge i_clk_sys);
   endtask
   // send one word on path p and time its arrival
   task automatic meas(input int p, input int c);
      logic [31:0] m;
      m = (p == 0) ? 32'hFFFFFFFF : ((p == 1) ? 32'h0000FFFF : 32'h00000FFF);
      val = $random(seed) & m;
      if (val === cur[p]) val = ~val & m;
      last[p] = val;
      @(negedge i_clk_sys);
      t_chg[p] = -1;
      i_sla_host_model.push(p[1:0], val);
      for (int n = 0; n < 32'h200 && t_chg[p] < 0; n++) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      `CHK(t_chg[p] - t_take, lat(c, p) + 1, "delay mismatch")
      `CHK(cur[p], val, "value mismatch")
      @(posedge i_clk_sys);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the full sequence needs well under this many cycles
   initial
   begin
      repeat (32'hC350) @(posedge i_clk_sys);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   // main sequence
   initial
   begin
      seed = 32'h023F2E71;
      {n_fail, comparisons, cyc, t_take} = '0;
      {slow, i_wr_en, i_rd_en, i_upd_hold, i_addr, i_wr_data} = '0;
      i_sys_rst = 1'b1;
      repeat (5) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(negedge i_clk_sys);
      `CHK({upd_ready, o_freq, o_phase, o_amp}, {1'b1, 60'h0}, "reset state")
      @(posedge i_clk_sys);
      rd(8'h20, 32'h0, "unmapped read");
      wr(8'h08, 32'h0);
      rd(8'h08, lat(0, 0), "read-only register changed");
      $display("test reset and map done");
      for (int c = 0; c < 16; c++)
      begin
         slow <= c[0];
         wr(8'h00, c);
         rd(8'h00, c, "control readback");
         for (int p = 0; p < 3; p++) rd(8'h08 + 8'(4 * p), lat(c, p), "delay register");
         repeat (32'h190) @(posedge i_clk_sys);
         for (int p = 0; p < 3; p++) meas(p, c);
         $display("test config %0d done", c);
      end
      rd(8'h14, last[0], "frequency readback");
      rd(8'h18, last[1], "phase readback");
      rd(8'h1C, last[2], "amplitude readback");
      slow <= 1'b0;
      i_upd_hold <= 1'b1;
      @(negedge i_clk_sys);
      for (int n = 0; n < 3; n++) i_sla_host_model.push(2'h0, $random(seed));
      last[0] = i_sla_host_model.q[2].data;
      repeat (8) @(posedge i_clk_sys);
      rd(8'h04, 32'h7, "status while held");
      `CHK(upd_ready, 1'b0, "buffer took a third word")
      i_upd_hold <= 1'b0;
      repeat (32'h190) @(posedge i_clk_sys);
      rd(8'h04, 32'h0, "status after drain");
      rd(8'h14, last[0], "word lost in buffer");
      $display("test buffer stall done");
      complete_run();
   end
endmodule
`default_nettype wire
